// ===== shared/rac_pkg.sv
// constants for the alarm compare register block
package rac_pkg;
	localparam logic [7:0] RAC_OFS_A1_HOURS    = 8'h11;
	localparam logic [7:0] RAC_OFS_FIRST_ALARM_DAYDATE_UNITS = 8'h12;
	localparam logic [7:0] RAC_OFS_FIRST_ALARM_MON_UNITS    = 8'h13;
	localparam logic [7:0] RAC_OFS_FIRST_ALARM_YR_UNITS     = 8'h14;
	localparam logic [7:0] RAC_OFS_SECOND_ALARM_MIN_UNITS  = 8'h15;
	localparam logic [7:0] RAC_OFS_A2_HOURS    = 8'h16;
	localparam logic [7:0] RAC_OFS_SECOND_ALARM_DAYDATE_UNITS = 8'h17;
	localparam logic [7:0] RAC_RESET_VAL       = 8'h00;
	localparam int RAC_MASK_BIT = 7;
	localparam int RAC_SEL_BIT  = 6;
	localparam int RAC_YRM_BIT  = 6;
	localparam logic [7:0] RAC_HOURS_CMP = 8'h3f;
	localparam logic [7:0] RAC_DATE_CMP  = 8'h3f;
	localparam logic [7:0] RAC_DAY_CMP   = 8'h07;
	localparam logic [7:0] RAC_MONTH_CMP = 8'h1f;
	localparam logic [7:0] RAC_MIN_CMP   = 8'h7f;
	localparam logic [7:0] RAC_HOURS_WR  = 8'hbf;
	localparam logic [7:0] RAC_DD_WR     = 8'hff;
	localparam logic [7:0] RAC_MONTH_WR  = 8'hdf;
	localparam logic [7:0] RAC_MIN_WR    = 8'hff;
endpackage

// ===== logic/rac_alarm_regs.sv
// alarm setting registers and match detection for both alarms
`timescale 1ns/1ns
`default_nettype none
module rac_alarm_regs
	import rac_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       rstn,
	input  wire logic       reg_wr,
	input  wire logic [7:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	output logic      [7:0] reg_rdata,
	input  wire logic [7:0] tk_seconds,
	input  wire logic [7:0] tk_minutes,
	input  wire logic [7:0] tk_hours,
	input  wire logic [7:0] tk_day,
	input  wire logic [7:0] tk_date,
	input  wire logic [7:0] tk_month,
	input  wire logic [7:0] tk_year,
	input  wire logic [7:0] first_alarm_sec_set,
	input  wire logic [7:0] first_alarm_min_set,
	input  wire logic       tick,
	input  wire logic       first_alarm_flag_clr,
	input  wire logic       second_alarm_flag_clr,
	output logic            first_alarm_flag_q,
	output logic            second_alarm_flag_q
);
	logic [7:0] a1_hours_q;
	logic [7:0] a1_dd_q;
	logic [7:0] first_alarm_mon_units_q;
	logic [7:0] first_alarm_yr_units_q;
	logic [7:0] a2_min_q;
	logic [7:0] a2_hours_q;
	logic [7:0] a2_dd_q;
	logic       a1_hit;
	logic       a2_hit;
	logic       a1_hit_q;
	logic       a2_hit_q;
	logic [7:0] rdata_d;

	// masked field compare over selected bits
	function automatic logic fld_ok(input logic msk, input logic [7:0] a,
		input logic [7:0] t, input logic [7:0] sel);
		fld_ok = msk | ((a & sel) == (t & sel));
	endfunction

	// day/date compare: weekday uses only bits 2:0
	function automatic logic dd_ok(input logic [7:0] a, input logic [7:0] day,
		input logic [7:0] date);
		if (a[RAC_SEL_BIT])
			dd_ok = a[RAC_MASK_BIT] | ((a & RAC_DAY_CMP) == (day & RAC_DAY_CMP));
		else
			dd_ok = a[RAC_MASK_BIT] | ((a & RAC_DATE_CMP) == (date & RAC_DATE_CMP));
	endfunction

	// bit 5 compares as pm flag or twenties digit; both are plain bit equality,
	// so the format bit (tk_hours[6]) only changes meaning, not the compare
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			a1_hours_q <= RAC_RESET_VAL;
			a1_dd_q    <= RAC_RESET_VAL;
			first_alarm_mon_units_q <= RAC_RESET_VAL;
			first_alarm_yr_units_q  <= RAC_RESET_VAL;
			a2_min_q   <= RAC_RESET_VAL;
			a2_hours_q <= RAC_RESET_VAL;
			a2_dd_q    <= RAC_RESET_VAL;
		end
		else if (reg_wr)
		begin
			case (reg_addr)
				RAC_OFS_A1_HOURS:    a1_hours_q <= reg_wdata & RAC_HOURS_WR;
				RAC_OFS_FIRST_ALARM_DAYDATE_UNITS: a1_dd_q    <= reg_wdata & RAC_DD_WR;
				RAC_OFS_FIRST_ALARM_MON_UNITS:    first_alarm_mon_units_q <= reg_wdata & RAC_MONTH_WR;
				RAC_OFS_FIRST_ALARM_YR_UNITS:     first_alarm_yr_units_q  <= reg_wdata;
				RAC_OFS_SECOND_ALARM_MIN_UNITS:  a2_min_q   <= reg_wdata & RAC_MIN_WR;
				RAC_OFS_A2_HOURS:    a2_hours_q <= reg_wdata & RAC_HOURS_WR;
				RAC_OFS_SECOND_ALARM_DAYDATE_UNITS: a2_dd_q    <= reg_wdata & RAC_DD_WR;
				default:             ;
			endcase
		end
	end

	always_comb
	begin
		case (reg_addr)
			RAC_OFS_A1_HOURS:    rdata_d = a1_hours_q;
			RAC_OFS_FIRST_ALARM_DAYDATE_UNITS: rdata_d = a1_dd_q;
			RAC_OFS_FIRST_ALARM_MON_UNITS:    rdata_d = first_alarm_mon_units_q;
			RAC_OFS_FIRST_ALARM_YR_UNITS:     rdata_d = first_alarm_yr_units_q;
			RAC_OFS_SECOND_ALARM_MIN_UNITS:  rdata_d = a2_min_q;
			RAC_OFS_A2_HOURS:    rdata_d = a2_hours_q;
			RAC_OFS_SECOND_ALARM_DAYDATE_UNITS: rdata_d = a2_dd_q;
			default:             rdata_d = 8'h00;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			reg_rdata <= 8'h00;
		else
			reg_rdata <= rdata_d;
	end

	assign a1_hit = fld_ok(first_alarm_sec_set[RAC_MASK_BIT], first_alarm_sec_set,
			tk_seconds, RAC_MIN_CMP)
		& fld_ok(first_alarm_min_set[RAC_MASK_BIT], first_alarm_min_set,
			tk_minutes, RAC_MIN_CMP)
		& fld_ok(a1_hours_q[RAC_MASK_BIT], a1_hours_q, tk_hours, RAC_HOURS_CMP)
		& dd_ok(a1_dd_q, tk_day, tk_date)
		& fld_ok(first_alarm_mon_units_q[RAC_MASK_BIT], first_alarm_mon_units_q, tk_month, RAC_MONTH_CMP)
		& fld_ok(first_alarm_mon_units_q[RAC_YRM_BIT], first_alarm_yr_units_q, tk_year, 8'hff);

	assign a2_hit = fld_ok(a2_min_q[RAC_MASK_BIT], a2_min_q, tk_minutes, RAC_MIN_CMP)
		& fld_ok(a2_hours_q[RAC_MASK_BIT], a2_hours_q, tk_hours, RAC_HOURS_CMP)
		& dd_ok(a2_dd_q, tk_day, tk_date);

	// compare only on the time tick; hit latches hold previous-tick match
	// so a flag fires on the tick where the match begins, not repeatedly
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			a1_hit_q <= 1'b0;
			a2_hit_q <= 1'b0;
		end
		else if (tick)
		begin
			a1_hit_q <= a1_hit;
			a2_hit_q <= a2_hit;
		end
	end

	// set wins over a clear in the same cycle
	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			first_alarm_flag_q <= 1'b0;
		else if (tick && a1_hit && !a1_hit_q)
			first_alarm_flag_q <= 1'b1;
		else if (first_alarm_flag_clr)
			first_alarm_flag_q <= 1'b0;
	end

	always_ff @(posedge sys_clk or negedge rstn)
	begin
		if (!rstn)
			second_alarm_flag_q <= 1'b0;
		else if (tick && a2_hit && !a2_hit_q)
			second_alarm_flag_q <= 1'b1;
		else if (second_alarm_flag_clr)
			second_alarm_flag_q <= 1'b0;
	end
endmodule
`default_nettype wire

// ===== bench/rac_host_model.sv
// host side register access model
`timescale 1ns/1ns
`default_nettype none
module rac_host_model
(
	input  wire logic       sys_clk,
	input  wire logic [7:0] reg_rdata,
	output var  logic       reg_wr,
	output var  logic [7:0] reg_addr,
	output var  logic [7:0] reg_wdata
);
	initial {reg_wr, reg_addr, reg_wdata} = {1'b0, 8'h00, 8'h00};
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk) {reg_wr, reg_addr, reg_wdata} = {1'b1, a, d};
		@(negedge sys_clk) reg_wr = 1'b0;
	endtask
	// read data is registered, so hold the offset two edges
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge sys_clk) reg_addr = a;
		repeat (2) @(negedge sys_clk);
		d = reg_rdata;
	endtask
endmodule
`default_nettype wire

// ===== bench/rac_alarm_regs_properties.sv
// assertions on the alarm register block ports
`timescale 1ns/1ns
`default_nettype none
module rac_alarm_regs_properties
(
	input wire logic       sys_clk,
	input wire logic       rstn,
	input wire logic       reg_wr,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic [7:0] reg_rdata,
	input wire logic       tick,
	input wire logic       first_alarm_flag_clr,
	input wire logic       first_alarm_flag_q
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	sequence s_wr(a);
		reg_wr && reg_addr == a ##1 !reg_wr && reg_addr == a;
	endsequence
	property p_wb(a, m);
		s_wr(a) |=> reg_rdata == ($past(reg_wdata, 2) & m);
	endproperty
	a_hours_wb: assert property (p_wb(8'h11, 8'hbf)) else $error("readback");
	a_month_wb: assert property (p_wb(8'h13, 8'hdf)) else $error("readback");
	a_year_wb: assert property (p_wb(8'h14, 8'hff)) else $error("readback");
	a_hours2_wb: assert property (p_wb(8'h16, 8'hbf)) else $error("readback");
	a_unmapped_zero: assert property (reg_addr > 8'h17 |=> reg_rdata == 8'h00) else $error("read");
	a_flag_cause: assert property ($rose(first_alarm_flag_q) |-> $past(tick) || $past(tick, 2))
		else $error("flag rose without tick");
	a_flag_sticky: assert property (first_alarm_flag_q && !first_alarm_flag_clr |=> first_alarm_flag_q)
		else $error("flag dropped");
	a_flag_clear: assert property (first_alarm_flag_clr && !tick && !$past(tick) |=> !first_alarm_flag_q)
		else $error("flag not cleared");
endmodule
bind rac_alarm_regs rac_alarm_regs_properties i_rac_alarm_regs_properties (.*);
`default_nettype wire

// ===== bench/rac_alarm_regs_bench.sv
// self-checking bench for the alarm register block
`timescale 1ns/1ns
`default_nettype none
module rac_alarm_regs_bench;
	logic        sys_clk = 1'b0, rstn = 1'b0, tick = 1'b0, reg_wr;
	logic        first_alarm_flag_clr = 1'b0, second_alarm_flag_clr = 1'b0;
	logic        first_alarm_flag_q, second_alarm_flag_q;
	logic [7:0]  reg_addr, reg_wdata, reg_rdata, d, tk_seconds = 8'h00, tk_minutes = 8'h30;
	logic [7:0]  tk_hours = 8'h00, tk_day = 8'h03, tk_date = 8'h15, tk_month = 8'h01;
	logic [7:0]  tk_year = 8'h24, first_alarm_sec_set = 8'h80, first_alarm_min_set = 8'h80;
	logic [23:0] rows [7] = '{24'h114505, 24'h12ffff, 24'h13ffdf, 24'h149999, 24'h15ffff,
		24'h16ffbf, 24'h17c5c5};
	int          error_cnt = 0, checks_done = 0, cyc = 0;
	rac_alarm_regs i_rac_alarm_regs (.*);
	rac_host_model i_rac_host_model (.*);
	always #5 sys_clk = ~sys_clk;
	always @(posedge sys_clk)
		if (++cyc == 2000)
		begin
			error_cnt++;
			end_sim;
		end
	task automatic chk(input logic [7:0] s, input logic [7:0] e);
		checks_done++;
		if (s !== e)
		begin
			error_cnt++;
			$display("BAD %0t %h %h", $time, s, e);
		end
	endtask
	task automatic end_sim;
		if (error_cnt == 0 && checks_done > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// two settle edges cover a flag set at or after the tick edge
	task automatic tk(input logic [7:0] e);
		@(negedge sys_clk) tick = 1'b1;
		@(negedge sys_clk) tick = 1'b0;
		repeat (2) @(negedge sys_clk);
		chk({6'h00, second_alarm_flag_q, first_alarm_flag_q}, e);
	endtask
	task automatic clr;
		@(negedge sys_clk) {first_alarm_flag_clr, second_alarm_flag_clr} = 2'b11;
		@(negedge sys_clk) {first_alarm_flag_clr, second_alarm_flag_clr} = 2'b00;
	endtask
	initial
	begin
		repeat (3) @(negedge sys_clk);
		rstn = 1'b1;
		foreach (rows[i])
		begin
			i_rac_host_model.wr(rows[i][23:16], rows[i][15:8]);
			i_rac_host_model.rd(rows[i][23:16], d);
			chk(d, rows[i][7:0]);
		end
		i_rac_host_model.wr(8'h18, 8'h5a);
		i_rac_host_model.rd(8'h18, d);
		chk(d, 8'h00);
		i_rac_host_model.wr(8'h15, 8'h30);
		i_rac_host_model.wr(8'h17, 8'h80);
		tk(8'h02);
		clr;
		tk(8'h00);
		i_rac_host_model.wr(8'h11, 8'h80);
		i_rac_host_model.wr(8'h12, 8'h43);
		tk(8'h01);
		clr;
		i_rac_host_model.wr(8'h12, 8'h03);
		tk(8'h00);
		i_rac_host_model.wr(8'h11, 8'h00);
		i_rac_host_model.wr(8'h13, 8'h01);
		i_rac_host_model.wr(8'h14, 8'h24);
		i_rac_host_model.wr(8'h12, 8'h43);
		tk(8'h01);
		clr;
		i_rac_host_model.wr(8'h14, 8'h25);
		tk(8'h00);
		i_rac_host_model.wr(8'h13, 8'h41);
		tk(8'h01);
		rstn = 1'b0;
		@(negedge sys_clk) rstn = 1'b1;
		i_rac_host_model.rd(8'h12, d);
		chk(d, 8'h00);
		end_sim;
	end
endmodule
`default_nettype wire
